/* rtl/cmd_link_if.sv */
`timescale 1ns/1ps
interface cmd_link_if;
	logic [7:0] opcode;
	logic [5:0] frame_len;
	logic frame_tgl;
	logic quad_mode;
	logic [23:0] table_addr;
	logic [7:0] table_byte;

	modport port (output opcode, frame_len, frame_tgl, table_addr, input quad_mode, table_byte);
	modport ctrl (input opcode, frame_len, frame_tgl, table_addr, output quad_mode, table_byte);
endinterface

/* rtl/flash_cmd_pkg.sv */
package flash_cmd_pkg;
	// ***********************************
	// opcodes
	// ***********************************
	localparam logic [7:0] OP_SUSPEND = 8'hB0;
	localparam logic [7:0] OP_RESUME = 8'h30;
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_RST_ARM = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	localparam logic [7:0] OP_QUAD_ENTER = 8'h35;
	localparam logic [7:0] OP_QUAD_EXIT = 8'hF5;
	localparam logic [7:0] OP_PARAM_READ = 8'h5A;
	localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;

	// ***********************************
	// frame timing in serial clocks, output enable masks
	// ***********************************
	localparam logic [5:0] SPI_OPC_CLKS = 6'h08;
	localparam logic [5:0] QPI_OPC_CLKS = 6'h02;
	localparam logic [5:0] SPI_ADDR_END = 6'h20;
	localparam logic [5:0] QPI_ADDR_END = 6'h08;
	localparam logic [5:0] SPI_DATA_START = 6'h28;
	localparam logic [5:0] QPI_DATA_START = 6'h0A;
	localparam logic [3:0] SPI_OUT_MASK = 4'h2;
	localparam logic [3:0] QPI_OUT_MASK = 4'hF;

	// ***********************************
	// parameter table header contents
	// ***********************************
	localparam logic [31:0] TBL_SIGNATURE = 32'h50444653;
	localparam logic [7:0] TBL_MINOR_REV = 8'h00;
	localparam logic [7:0] TBL_MAJOR_REV = 8'h01;
	localparam logic [7:0] TBL_HDR_COUNT = 8'h01;
	localparam logic [7:0] TBL_UNUSED = 8'hFF;
	localparam logic [7:0] HDR0_ID = 8'h00;
	localparam logic [7:0] HDR0_LEN = 8'h09;
	localparam logic [23:0] HDR0_PTR = 24'h000030;
	localparam logic [7:0] HDR1_LEN = 8'h04;
	localparam logic [23:0] HDR1_PTR = 24'h000060;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RUN = 4'h2,
		ST_PSUSP = 4'h4,
		ST_ESUSP = 4'h8
	} wr_state_t;

	// commands still served while a write is suspended
	function automatic logic suspend_safe(input logic [7:0] op);
		case (op)
			8'h03, 8'h0B, 8'hBB, 8'hEB, 8'hE7, 8'h9F, 8'hAF, 8'h90, 8'h05, 8'h2B, 8'hB1,
			8'hC1, 8'h5A, 8'h3C, 8'h30, 8'h66, 8'h99, 8'hC0, 8'h35, 8'hF5, 8'h00,
			8'hAB: suspend_safe = 1'b1;
			default: suspend_safe = 1'b0;
		endcase
	endfunction
endpackage

/* rtl/flash_suspend_reset_sfdp_ctrl.sv */
`timescale 1ns/1ps
module flash_suspend_reset_sfdp_ctrl #(
	parameter logic [7:0] VENDOR_ID_CODE = 8'hA5 // arbitrary value
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe_o,
	input wire logic wr_op_active_i,
	input wire logic wr_op_is_erase_i,
	input wire logic perf_enhance_i,
	output logic write_enable_latch_o,
	output logic program_suspended_flag_o,
	output logic erase_suspended_flag_o,
	output logic busy_o,
	output logic four_line_command_mode_o,
	output logic suspend_req_o,
	output logic resume_req_o,
	output logic soft_reset_o,
	output logic abort_req_o,
	output logic abort_was_program_o
);
	import flash_cmd_pkg::*;

	cmd_link_if lnk();

	// ***********************************
	// link side and header table
	// ***********************************
	link_port u_link (
		.sclk_i(sclk_i),
		.cs_n_i(cs_n_i),
		.reset_i(reset_i),
		.io_i(io_i),
		.io_o(io_o),
		.io_oe_o(io_oe_o),
		.lnk(lnk.port)
	);

	param_table #(.VENDOR_ID(VENDOR_ID_CODE)) u_table (
		.addr_i(lnk.table_addr),
		.data_o(lnk.table_byte)
	);

	// ***********************************
	// frame end detection
	// ***********************************
	logic cs_s1_reg, cs_s2_reg, cs_s3_reg, cs_hi_reg, cs_hi_next;
	logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg, tgl_seen_reg, tgl_seen_next;
	logic frame_end, new_frame, cmd_any, cmd_go, eff;
	logic [5:0] op_clks;
	logic [7:0] op;

	// frame end once second and third stages agree high
	always_comb begin
		cs_hi_next = cs_hi_reg;
		if (cs_s2_reg && cs_s3_reg) begin
			cs_hi_next = 1'b1;
		end else if (!cs_s2_reg && !cs_s3_reg) begin
			cs_hi_next = 1'b0;
		end
		frame_end = cs_s2_reg && cs_s3_reg && !cs_hi_reg;
		new_frame = (tgl_s2_reg == tgl_s3_reg) && (tgl_s3_reg != tgl_seen_reg);
		tgl_seen_next = frame_end ? tgl_s2_reg : tgl_seen_reg;
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_s3_reg <= 1'b1;
			cs_hi_reg <= 1'b1;
			tgl_s1_reg <= 1'b0;
			tgl_s2_reg <= 1'b0;
			tgl_s3_reg <= 1'b0;
			tgl_seen_reg <= 1'b0;
		end else begin
			cs_s1_reg <= cs_n_i;
			cs_s2_reg <= cs_s1_reg;
			cs_s3_reg <= cs_s2_reg;
			cs_hi_reg <= cs_hi_next;
			tgl_s1_reg <= lnk.frame_tgl;
			tgl_s2_reg <= tgl_s1_reg;
			tgl_s3_reg <= tgl_s2_reg;
			tgl_seen_reg <= tgl_seen_next;
		end
	end

	// ***********************************
	// command decode
	// ***********************************
	wr_state_t state_reg, state_next;
	logic wel_reg, wel_next, quad_reg, quad_next, arm_reg, arm_next;
	logic pflag_next, eflag_next, busy_next, act_q_reg;
	logic susp_next, res_next, srst_next, abort_next, abort_prog_next;
	logic suspended;

	// link words are stable here: the serial clock has stopped
	assign op = lnk.opcode;
	assign op_clks = quad_reg ? QPI_OPC_CLKS : SPI_OPC_CLKS;
	assign cmd_any = frame_end && new_frame && (lnk.frame_len >= op_clks);
	assign cmd_go = frame_end && new_frame && (lnk.frame_len == op_clks);
	assign suspended = (state_reg == ST_PSUSP) || (state_reg == ST_ESUSP);
	assign eff = cmd_go && (!suspended || suspend_safe(op));
	assign lnk.quad_mode = quad_reg;

	// ***********************************
	// write, suspend and reset control
	// ***********************************
	always_comb begin
		state_next = state_reg;
		wel_next = wel_reg;
		quad_next = quad_reg;
		arm_next = cmd_any ? 1'b0 : arm_reg;
		susp_next = 1'b0;
		res_next = 1'b0;
		srst_next = 1'b0;
		abort_next = 1'b0;
		abort_prog_next = abort_was_program_o;
		unique case (state_reg)
			ST_IDLE: begin
				if (wr_op_active_i && !act_q_reg) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!wr_op_active_i) begin
					state_next = ST_IDLE;
				end
			end
			ST_PSUSP, ST_ESUSP: begin
			end
		endcase
		if (eff) begin
			if (op == OP_RST_ARM) begin
				arm_next = 1'b1;
			end else if (op == OP_RST && arm_reg) begin
				state_next = ST_IDLE;
				wel_next = 1'b0;
				quad_next = 1'b0;
				srst_next = 1'b1;
				abort_next = state_reg != ST_IDLE;
				abort_prog_next = (state_reg == ST_PSUSP) ||
					(state_reg == ST_RUN && !wr_op_is_erase_i);
			end else if (op == OP_WRITE_ENABLE_CMD) begin
				wel_next = 1'b1;
			end else if (op == OP_WRDI) begin
				wel_next = 1'b0;
			end else if (op == OP_SUSPEND && state_reg == ST_RUN) begin
				state_next = wr_op_is_erase_i ? ST_ESUSP : ST_PSUSP;
				wel_next = 1'b0;
				susp_next = 1'b1;
			end else if (op == OP_RESUME && suspended && !perf_enhance_i) begin
				state_next = ST_RUN;
				res_next = 1'b1;
			end else if (op == OP_QUAD_ENTER) begin
				quad_next = 1'b1;
			end else if (op == OP_QUAD_EXIT) begin
				quad_next = 1'b0;
			end
		end
		pflag_next = state_next == ST_PSUSP;
		eflag_next = state_next == ST_ESUSP;
		busy_next = state_next == ST_RUN;
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= ST_IDLE;
			wel_reg <= 1'b0;
			quad_reg <= 1'b0;
			arm_reg <= 1'b0;
			act_q_reg <= 1'b0;
			program_suspended_flag_o <= 1'b0;
			erase_suspended_flag_o <= 1'b0;
			busy_o <= 1'b0;
			suspend_req_o <= 1'b0;
			resume_req_o <= 1'b0;
			soft_reset_o <= 1'b0;
			abort_req_o <= 1'b0;
			abort_was_program_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			wel_reg <= wel_next;
			quad_reg <= quad_next;
			arm_reg <= arm_next;
			act_q_reg <= wr_op_active_i;
			program_suspended_flag_o <= pflag_next;
			erase_suspended_flag_o <= eflag_next;
			busy_o <= busy_next;
			suspend_req_o <= susp_next;
			resume_req_o <= res_next;
			soft_reset_o <= srst_next;
			abort_req_o <= abort_next;
			abort_was_program_o <= abort_prog_next;
		end
	end

	assign write_enable_latch_o = wel_reg;
	assign four_line_command_mode_o = quad_reg;

	// ***********************************
	// checks
	// ***********************************
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);

	property p_susp_clears_wel;
		suspend_req_o |-> !write_enable_latch_o && (program_suspended_flag_o || erase_suspended_flag_o);
	endproperty
	a_susp_clears_wel: assert property (p_susp_clears_wel) else $error("suspend left wel set");

	property p_psusp_flag;
		(eff && op == OP_SUSPEND && state_reg == ST_RUN && !wr_op_is_erase_i)
			|=> program_suspended_flag_o && !busy_o && suspend_req_o;
	endproperty
	a_psusp_flag: assert property (p_psusp_flag) else $error("program suspend flag not set");

	property p_esusp_flag;
		erase_suspended_flag_o && resume_req_o |-> 0;
	endproperty
	a_esusp_flag: assert property (p_esusp_flag) else $error("erase flag held over resume");

	property p_resume_clears;
		resume_req_o |-> busy_o && !program_suspended_flag_o && !erase_suspended_flag_o;
	endproperty
	a_resume_clears: assert property (p_resume_clears) else $error("resume left a flag set");

	property p_resume_no_wel;
		(eff && op == OP_RESUME && suspended && !perf_enhance_i && !wel_reg) |=> resume_req_o;
	endproperty
	a_resume_no_wel: assert property (p_resume_no_wel) else $error("resume refused without wel");

	property p_perf_blocks;
		(cmd_go && op == OP_RESUME && perf_enhance_i && suspended)
			|=> !resume_req_o && $stable(program_suspended_flag_o) && !busy_o;
	endproperty
	a_perf_blocks: assert property (p_perf_blocks) else $error("resume taken in perf mode");

	property p_nop_disarms;
		(cmd_any && op == OP_NOP) ##1 (!cmd_any)[*2] |-> !arm_reg;
	endproperty
	a_nop_disarms: assert property (p_nop_disarms) else $error("nop left reset armed");

	property p_reset_armed;
		$rose(soft_reset_o) |-> $past(arm_reg);
	endproperty
	a_reset_armed: assert property (p_reset_armed) else $error("reset without arm");

	property p_reset_defaults;
		soft_reset_o |-> !write_enable_latch_o && !four_line_command_mode_o &&
			!program_suspended_flag_o && !erase_suspended_flag_o && !busy_o;
	endproperty
	a_reset_defaults: assert property (p_reset_defaults) else $error("reset kept state");

	property p_abort_on_reset;
		(eff && op == OP_RST && arm_reg && state_reg != ST_IDLE) |=> abort_req_o && soft_reset_o;
	endproperty
	a_abort_on_reset: assert property (p_abort_on_reset) else $error("no abort on reset");

	property p_quad_exit;
		(eff && op == OP_QUAD_EXIT) |=> !four_line_command_mode_o;
	endproperty
	a_quad_exit: assert property (p_quad_exit) else $error("quad mode not left");

	property p_ignore_susp;
		(cmd_go && suspended && op == OP_WRITE_ENABLE_CMD) |=> !write_enable_latch_o && $stable(state_reg);
	endproperty
	a_ignore_susp: assert property (p_ignore_susp) else $error("command acted while suspended");

	c_suspend: cover property (suspend_req_o);
	c_resume: cover property (resume_req_o);
	c_reset_abort: cover property (soft_reset_o && abort_req_o);
	c_table_read: cover property (cmd_any && op == OP_PARAM_READ);
endmodule

/* rtl/link_port.sv */
`timescale 1ns/1ps
module link_port (
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic reset_i,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe_o,
	cmd_link_if.port lnk
);
	import flash_cmd_pkg::*;

	logic [5:0] cnt_reg, cnt_next;
	logic [2:0] bit_reg, bit_next;
	logic drive_reg, drive_next;
	logic [7:0] sh_reg, sh_next;
	logic [7:0] op_reg, op_next;
	logic [5:0] len_reg, len_next;
	logic tgl_reg, tgl_next;
	logic [23:0] addr_reg, addr_next;
	logic [7:0] out_reg, out_next;
	logic [3:0] io_next, oe_next;
	logic q, byte_end;
	logic [5:0] opc, aend, ds;
	logic [7:0] in_sh;

	// quad mode only changes while chip select is high, so it is static here
	assign q = lnk.quad_mode;
	assign opc = q ? QPI_OPC_CLKS : SPI_OPC_CLKS;
	assign aend = q ? QPI_ADDR_END : SPI_ADDR_END;
	assign ds = q ? QPI_DATA_START : SPI_DATA_START;
	assign in_sh = q ? {sh_reg[3:0], io_i} : {sh_reg[6:0], io_i[0]};
	assign byte_end = q ? bit_reg[0] : (bit_reg == 3'h7);
	assign lnk.opcode = op_reg;
	assign lnk.frame_len = len_reg;
	assign lnk.frame_tgl = tgl_reg;
	assign lnk.table_addr = addr_reg;

	// ***********************************
	// receive and stream, rising edge
	// ***********************************
	always_comb begin
		cnt_next = (cnt_reg == 6'h3F) ? cnt_reg : cnt_reg + 6'h01;
		bit_next = bit_reg + 3'h1;
		sh_next = in_sh;
		len_next = cnt_next;
		tgl_next = (cnt_reg == 6'h00) ? ~tgl_reg : tgl_reg;
		op_next = (cnt_reg == opc - 6'h01) ? in_sh : op_reg;
		addr_next = addr_reg;
		out_next = out_reg;
		drive_next = drive_reg;
		if (cnt_reg >= opc && cnt_reg < aend) begin
			addr_next = q ? {addr_reg[19:0], io_i} : {addr_reg[22:0], io_i[0]};
		end
		if (op_reg == OP_PARAM_READ && cnt_reg >= ds - 6'h01 && byte_end) begin
			out_next = lnk.table_byte;
			addr_next = addr_reg + 24'h000001;
			drive_next = 1'b1;
		end else if (drive_reg) begin
			out_next = q ? {out_reg[3:0], 4'hF} : {out_reg[6:0], 1'b1};
		end
	end

	// frame counters restart whenever chip select is high
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			cnt_reg <= 6'h00;
			bit_reg <= 3'h0;
			drive_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			drive_reg <= drive_next;
		end
	end

	// frame results survive chip select rising for the control side
	always_ff @(posedge sclk_i or posedge reset_i) begin
		if (reset_i) begin
			sh_reg <= 8'h00;
			op_reg <= 8'h00;
			len_reg <= 6'h00;
			tgl_reg <= 1'b0;
			addr_reg <= 24'h000000;
			out_reg <= 8'hFF;
		end else begin
			sh_reg <= sh_next;
			op_reg <= op_next;
			len_reg <= len_next;
			tgl_reg <= tgl_next;
			addr_reg <= addr_next;
			out_reg <= out_next;
		end
	end

	// ***********************************
	// pin drive, falling edge
	// ***********************************
	always_comb begin
		io_next = q ? out_reg[7:4] : {2'b00, out_reg[7], 1'b0};
		oe_next = drive_reg ? (q ? QPI_OUT_MASK : SPI_OUT_MASK) : 4'h0;
	end

	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			io_o <= 4'h0;
			io_oe_o <= 4'h0;
		end else begin
			io_o <= io_next;
			io_oe_o <= oe_next;
		end
	end
endmodule

/* rtl/param_table.sv */
`timescale 1ns/1ps
module param_table #(
	parameter logic [7:0] VENDOR_ID = 8'hA5 // arbitrary value
) (
	input wire logic [23:0] addr_i,
	output logic [7:0] data_o
);
	import flash_cmd_pkg::*;

	// ***********************************
	// header bytes, everything else reads ff
	// ***********************************
	always_comb begin
		case (addr_i)
			24'h000000: data_o = TBL_SIGNATURE[7:0];
			24'h000001: data_o = TBL_SIGNATURE[15:8];
			24'h000002: data_o = TBL_SIGNATURE[23:16];
			24'h000003: data_o = TBL_SIGNATURE[31:24];
			24'h000004: data_o = TBL_MINOR_REV;
			24'h000005: data_o = TBL_MAJOR_REV;
			24'h000006: data_o = TBL_HDR_COUNT;
			24'h000008: data_o = HDR0_ID;
			24'h000009: data_o = TBL_MINOR_REV;
			24'h00000A: data_o = TBL_MAJOR_REV;
			24'h00000B: data_o = HDR0_LEN;
			24'h00000C: data_o = HDR0_PTR[7:0];
			24'h00000D: data_o = HDR0_PTR[15:8];
			24'h00000E: data_o = HDR0_PTR[23:16];
			24'h000010: data_o = VENDOR_ID;
			24'h000011: data_o = TBL_MINOR_REV;
			24'h000012: data_o = TBL_MAJOR_REV;
			24'h000013: data_o = HDR1_LEN;
			24'h000014: data_o = HDR1_PTR[7:0];
			24'h000015: data_o = HDR1_PTR[15:8];
			24'h000016: data_o = HDR1_PTR[23:16];
			default: data_o = TBL_UNUSED;
		endcase
	end
endmodule

/* tb/host_model.sv */
`timescale 1ns/1ps
module host_model (
	output logic sclk_o,
	output logic cs_n_o,
	output logic [3:0] io_o,
	input wire logic [3:0] io_i
);
	// ***********************************
	// idle levels: clock parked low, deselected
	// ***********************************
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		io_o = 4'h0;
	end

	// ***********************************
	// frame tasks
	// ***********************************
	// shifts units of one byte msb first, samples the device on rising edges
	task automatic shift(input logic quad, input logic [7:0] b, input int units,
		output logic [7:0] r);
		logic [7:0] sh;
		sh = b;
		r = 8'h00;
		cs_n_o = 1'b0;
		for (int i = 0; i < units; i++) begin
			if (quad) begin
				io_o = sh[7:4];
				sh = {sh[3:0], 4'h0};
			end else begin
				io_o = {~io_o[3:1], sh[7]}; // upper lines toggle as junk
				sh = {sh[6:0], 1'b0};
			end
			#6 sclk_o = 1'b1;
			r = quad ? {r[3:0], io_i} : {r[6:0], io_i[1]};
			#6 sclk_o = 1'b0;
		end
	endtask

	// deselect after the last edge, then keep the gap between frames
	task automatic stop();
		#10 cs_n_o = 1'b1;
		#70;
	endtask

	// one whole single-byte command
	task automatic op(input logic quad, input logic [7:0] b);
		logic [7:0] r;
		shift(quad, b, quad ? 2 : 8, r);
		stop();
	endtask

	// table read: opcode, three address bytes, dummy byte, then n bytes out
	task automatic table_read(input logic quad, input logic [23:0] addr, input int n,
		output logic [7:0] d [0:31]);
		logic [7:0] r;
		int u;
		u = quad ? 2 : 8;
		shift(quad, 8'h5A, u, r);
		shift(quad, addr[23:16], u, r);
		shift(quad, addr[15:8], u, r);
		shift(quad, addr[7:0], u, r);
		shift(quad, 8'h00, u, r);
		for (int i = 0; i < n; i++) begin
			shift(quad, 8'h00, u, d[i]);
		end
		stop();
	endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
`define CHECK(got, exp) \
	begin \
		check_count++; \
		if ((got) !== (exp)) begin \
			mismatches++; \
			$display("wrong value at %0t: %h instead of %h", $time, got, exp); \
		end \
	end
module testbench;
	import flash_cmd_pkg::*;
	localparam logic [7:0] VEND = 8'h5E; // arbitrary vendor value
	logic clk_sys_i, reset_i, sclk, cs_n, wr_active, wr_erase, perf;
	logic [3:0] host_io, dev_io, dev_oe, io_line;
	logic write_enable_latch, psf, esf, busy, qmode, susp_req, res_req, soft_rst, abort_req, abort_prog;
	int mismatches = 0;
	int check_count = 0;
	int n_susp = 0, n_res = 0, n_rst = 0, n_abort = 0, cycles = 0;
	logic [7:0] d [0:31];
	logic [7:0] exp_tbl [0:24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF,
		8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
		VEND, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hFF, 8'hFF};

	// ***********************************
	// wiring: shared data lines resolved by output enables
	// ***********************************
	assign io_line = (dev_oe & dev_io) | (~dev_oe & host_io);
	host_model u_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(host_io), .io_i(io_line));
	flash_suspend_reset_sfdp_ctrl #(.VENDOR_ID_CODE(VEND)) u_flash_suspend_reset_sfdp_ctrl (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.io_i(io_line), .io_o(dev_io), .io_oe_o(dev_oe), .wr_op_active_i(wr_active),
		.wr_op_is_erase_i(wr_erase), .perf_enhance_i(perf), .write_enable_latch_o(write_enable_latch),
		.program_suspended_flag_o(psf), .erase_suspended_flag_o(esf), .busy_o(busy),
		.four_line_command_mode_o(qmode), .suspend_req_o(susp_req), .resume_req_o(res_req),
		.soft_reset_o(soft_rst), .abort_req_o(abort_req), .abort_was_program_o(abort_prog));

	// ***********************************
	// clock, pulse counters, timeout
	// ***********************************
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		n_susp += (susp_req === 1'b1);
		n_res += (res_req === 1'b1);
		n_rst += (soft_rst === 1'b1);
		n_abort += (abort_req === 1'b1);
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			finish_test();
		end
	end

	// ***********************************
	// helpers
	// ***********************************
	task automatic finish_test();
		if (mismatches == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic cmd(input logic q, input logic [7:0] op);
		u_host_model.op(q, op);
		@(posedge clk_sys_i);
		#2;
	endtask
	// array engine levels, then time for the status to follow
	task automatic engine(input logic act, input logic er, input logic pe);
		@(posedge clk_sys_i);
		#1;
		wr_active = act;
		wr_erase = er;
		perf = pe;
		repeat (3) @(posedge clk_sys_i);
		#2;
	endtask

	// ***********************************
	// scenarios
	// ***********************************
	task automatic t_program_suspend();
		cmd(1'b0, OP_WRITE_ENABLE_CMD);
		engine(1'b1, 1'b0, 1'b0);
		`CHECK(busy, 1'b1)
		cmd(1'b0, OP_SUSPEND);
		`CHECK({psf, esf, busy, write_enable_latch}, 4'h8)
		#18000;
		cmd(1'b0, OP_WRITE_ENABLE_CMD);
		cmd(1'b0, OP_SUSPEND);
		`CHECK({write_enable_latch, n_susp}, {1'b0, 32'd1})
		engine(1'b1, 1'b0, 1'b1);
		cmd(1'b0, OP_RESUME);
		`CHECK({psf, n_res}, {1'b1, 32'd0})
		engine(1'b1, 1'b0, 1'b0);
		cmd(1'b0, OP_RESUME);
		`CHECK({psf, busy, n_res}, {2'b01, 32'd1})
		engine(1'b0, 1'b0, 1'b0);
		`CHECK(busy, 1'b0)
	endtask

	task automatic t_erase_quad();
		cmd(1'b0, OP_QUAD_ENTER);
		`CHECK(qmode, 1'b1)
		engine(1'b1, 1'b1, 1'b0);
		cmd(1'b1, OP_SUSPEND);
		`CHECK({esf, psf}, 2'b10)
		cmd(1'b1, OP_RESUME);
		`CHECK({esf, busy}, 2'b01)
		engine(1'b0, 1'b1, 1'b0);
		u_host_model.table_read(1'b1, 24'h000010, 9, d);
		for (int i = 0; i < 9; i++) begin
			`CHECK(d[i], exp_tbl[16 + i])
		end
		cmd(1'b1, OP_QUAD_EXIT);
		`CHECK(qmode, 1'b0)
		cmd(1'b0, OP_WRITE_ENABLE_CMD);
		`CHECK(write_enable_latch, 1'b1)
	endtask

	task automatic t_reset_seq();
		logic [7:0] r;
		cmd(1'b0, OP_RST_ARM);
		cmd(1'b0, OP_NOP);
		cmd(1'b0, OP_RST);
		`CHECK({n_rst, write_enable_latch}, {32'd0, 1'b1})
		cmd(1'b0, OP_RST_ARM);
		cmd(1'b0, OP_WRITE_ENABLE_CMD);
		cmd(1'b0, OP_RST);
		`CHECK(n_rst, 0)
		engine(1'b1, 1'b0, 1'b0);
		cmd(1'b0, OP_RST_ARM);
		u_host_model.shift(1'b0, 8'h00, 5, r);
		u_host_model.stop();
		cmd(1'b0, OP_RST);
		`CHECK(n_rst, 1)
		`CHECK({n_abort, abort_prog}, {32'd1, 1'b1})
		`CHECK({write_enable_latch, busy, psf, esf, qmode}, 5'h00)
		engine(1'b0, 1'b0, 1'b0);
		repeat (300) @(posedge clk_sys_i);
	endtask

	// erase aborted from suspend, resumed without write enable
	task automatic t_erase_abort();
		cmd(1'b0, OP_WRITE_ENABLE_CMD);
		cmd(1'b0, OP_WRDI);
		`CHECK(write_enable_latch, 1'b0)
		engine(1'b1, 1'b1, 1'b0);
		cmd(1'b0, OP_SUSPEND);
		`CHECK({esf, busy}, 2'b10)
		cmd(1'b0, OP_RESUME);
		`CHECK({esf, busy, n_res}, {2'b01, 32'd3})
		cmd(1'b0, OP_SUSPEND);
		#18000;
		cmd(1'b0, OP_RST_ARM);
		cmd(1'b0, OP_RST);
		`CHECK({n_rst, n_abort, abort_prog}, {32'd2, 32'd2, 1'b0})
		`CHECK({esf, busy}, 2'b00)
		engine(1'b0, 1'b0, 1'b0);
	endtask

	task automatic t_table_single();
		u_host_model.table_read(1'b0, 24'h000000, 25, d);
		for (int i = 0; i < 25; i++) begin
			`CHECK(d[i], exp_tbl[i])
		end
		`CHECK(dev_oe, 4'h0)
	endtask

	// ***********************************
	// main sequence
	// ***********************************
	initial begin
		reset_i = 1'b1;
		wr_active = 1'b0;
		wr_erase = 1'b0;
		perf = 1'b0;
		repeat (5) @(posedge clk_sys_i);
		#1;
		reset_i = 1'b0;
		repeat (4) @(posedge clk_sys_i);
		#2;
		`CHECK({write_enable_latch, psf, esf, busy, qmode}, 5'h00)
		t_table_single();
		t_program_suspend();
		t_erase_quad();
		t_reset_seq();
		t_erase_abort();
		finish_test();
	end
endmodule
